// file: core/pfrd_pkg.sv
// pfrd_pkg: constants for the parallel frequency reference decoder
// assumes: included before the interface and the design modules
package pfrd_pkg;
    // input format selector codes
    localparam logic [2:0] FMT_BCD_1PCT = 3'h0;
    localparam logic [2:0] FMT_BCD_P1PCT = 3'h1;
    localparam logic [2:0] FMT_BCD_P01PCT = 3'h2;
    localparam logic [2:0] FMT_BCD_1HZ = 3'h3;
    localparam logic [2:0] FMT_BCD_P1HZ = 3'h4;
    localparam logic [2:0] FMT_BCD_P01HZ = 3'h5;
    localparam logic [2:0] FMT_BCD5 = 3'h6;
    localparam logic [2:0] FMT_BINARY = 3'h7;
    localparam logic [2:0] FMT_RESET = 3'h0;
    // display scaling boundaries
    localparam logic [15:0] SCALE_HZ = 16'h0000;
    localparam logic [15:0] SCALE_PCT = 16'h0001;
    localparam logic [15:0] SCALE_RPM_MIN = 16'h0002;
    localparam logic [15:0] SCALE_RPM_MAX = 16'h0027;
    localparam logic [15:0] SCALE_USER_MIN = 16'h0028;
    localparam logic [15:0] SCALE_USER_MAX = 16'h9C3F;
    localparam logic [15:0] SCALE_RESET = 16'h0000;
    // full scale (100 %) in 0.01 % units
    localparam logic [19:0] FULL_PCT = 20'h02710;
    // weight of the sign pin when it serves as fifth-digit bit 2
    localparam logic [19:0] BCD5_SIGN_WEIGHT = 20'h04E20;
    // wide terminal word: 10 + 6 data pins
    localparam int WIDE_BITS = 16;
    localparam int NARROW_BITS = 8;
    // unit classes of the result
    typedef enum logic [1:0] {
        PFRD_UNIT_HZ,
        PFRD_UNIT_PCT,
        PFRD_UNIT_RPM,
        PFRD_UNIT_USER
    } pfrd_unit_t;
endpackage

// file: core/pfrd_word_if.sv
// pfrd_word_if: captured terminal word handed to the digit decoder
// assumes: one clock domain, source is the top module
`timescale 1ns/10ps
`default_nettype none
interface pfrd_word_if;
    logic [15:0] word;
    logic [2:0] fmt;
    logic wide;
    logic force_bcd;
    logic [19:0] mag;
    logic bad;
    modport src (output word, output fmt, output wide, output force_bcd,
        input mag, input bad);
    modport dec (input word, input fmt, input wide, input force_bcd,
        output mag, output bad);
endinterface
`default_nettype wire

// file: core/pfrd_digits.sv
// pfrd_digits: combinational weighting of the captured terminal word
// assumes: word held stable by the caller between captures
`timescale 1ns/10ps
`default_nettype none
module pfrd_digits
    import pfrd_pkg::*;
(
    // captured word and mode
    pfrd_word_if.dec w
);
    logic [3:0] d0, d1, d2, d3, d4;
    logic [19:0] bcd_val;
    logic digit_bad;

    // ----------------------------------------------------------------
    // digit extraction
    // ----------------------------------------------------------------
    always_comb begin
        if (w.fmt == FMT_BCD5 && !w.force_bcd) begin
            // lowest digit starts at weight 2 on pin 1
            d0 = {w.word[2:0], 1'b0};
            d1 = w.word[6:3];
            d2 = w.word[10:7];
            d3 = w.word[14:11];
            d4 = {3'h0, w.word[15]};
        end else begin
            d0 = w.word[3:0];
            d1 = w.word[7:4];
            d2 = w.word[11:8];
            d3 = w.wide ? w.word[15:12] : 4'h0;
            d4 = 4'h0;
        end
    end

    always_comb begin
        bcd_val = 20'(d0) + 20'(d1) * 20'd10 + 20'(d2) * 20'd100
            + 20'(d3) * 20'd1000 + 20'(d4) * 20'd10000;
        digit_bad = (d0 > 4'h9) || (d1 > 4'h9) || (d2 > 4'h9)
            || (d3 > 4'h9);
    end

    // ----------------------------------------------------------------
    // format select
    // ----------------------------------------------------------------
    always_comb begin
        if (w.fmt == FMT_BINARY && !w.force_bcd) begin
            // 12-bit keeps pins 1..12, 16-bit adds four more
            w.mag = w.wide ? {4'h0, w.word} : {8'h00, w.word[11:0]};
            w.bad = 1'b0;
        end else begin
            w.mag = bcd_val;
            w.bad = digit_bad;
        end
    end
endmodule
`default_nettype wire

// file: core/pfrd_top.sv
// pfrd_top: parallel frequency reference decoder, captures and scales
// assumes: terminal pins already synchronous to i_clk
`timescale 1ns/10ps
`default_nettype none
module pfrd_top
    import pfrd_pkg::*;
#(
    parameter int DATA_BITS = WIDE_BITS
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // terminal blocks: first has 10 data pins, second 6 data pins
    input wire logic [9:0] i_first_terminal_block,
    input wire logic [5:0] i_second_terminal_block,
    input wire logic i_sign,
    input wire logic i_read_strobe,
    // configuration
    input wire logic [2:0] i_digital_input_format_select,
    input wire logic [15:0] i_display_scaling_select,
    input wire logic i_word_width_switch,
    // result
    output logic [19:0] o_reference_mag,
    output logic o_reference_reverse,
    output logic o_reference_valid,
    output logic o_binary_full_scale,
    output logic o_format_error,
    output logic [1:0] o_reference_unit,
    output logic [15:0] o_unit_scale
);
    // is the operator's duty; nothing here depends on it

    if (DATA_BITS != WIDE_BITS && DATA_BITS != NARROW_BITS) begin : g_bad
        $error("pfrd_top: DATA_BITS must be 8 or 16");
    end

    localparam bit IS_WIDE = (DATA_BITS == WIDE_BITS);

    pfrd_word_if wif ();

    logic [15:0] pins;
    logic [15:0] word_q;
    logic sign_q;
    logic have_q;
    logic wide_eff;
    logic force_bcd;
    logic [2:0] fmt_eff;
    logic fmt_blocked;
    logic signed_fmt;
    pfrd_unit_t unit_d;

    // ----------------------------------------------------------------
    // pin assembly and mode
    // ----------------------------------------------------------------
    always_comb begin
        if (IS_WIDE) begin
            pins = {i_second_terminal_block, i_first_terminal_block};
        end else begin
            pins = {8'h00, i_first_terminal_block[7:0]};
        end
        // narrow variant has no switch, behaves as its own width
        wide_eff = IS_WIDE && i_word_width_switch;
        force_bcd = i_display_scaling_select >= SCALE_RPM_MIN;
        fmt_eff = i_digital_input_format_select;
        // code 6 needs the wide board and the wide switch
        fmt_blocked = (fmt_eff == FMT_BCD5) && !force_bcd
            && (!IS_WIDE || !i_word_width_switch);
        signed_fmt = force_bcd || fmt_eff != FMT_BCD5;
    end

    assign wif.word = word_q;
    assign wif.fmt = fmt_eff;
    assign wif.wide = wide_eff;
    assign wif.force_bcd = force_bcd;

    pfrd_digits u_digits (
        .w (wif)
    );

    // ----------------------------------------------------------------
    // capture while strobe is high and code 6 is not blocked, hold otherwise
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            word_q <= 16'h0000;
            sign_q <= 1'b0;
            have_q <= 1'b0;
        end else if (i_read_strobe && !fmt_blocked) begin
            word_q <= pins;
            sign_q <= i_sign;
            have_q <= 1'b1;
        end
        // strobe low keeps the last captured word
    end

    // ----------------------------------------------------------------
    // result registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_reference_mag <= 20'h00000;
            o_reference_reverse <= 1'b0;
            o_reference_valid <= 1'b0;
            o_format_error <= 1'b0;
        end else begin
            // unsigned code 6 reads the sign pin as digit 5 weight 2
            if (fmt_eff == FMT_BCD5 && !force_bcd && sign_q) begin
                o_reference_mag <= wif.mag + BCD5_SIGN_WEIGHT;
            end else begin
                o_reference_mag <= wif.mag;
            end
            // sign line: 0 forward, 1 reverse; unsigned code 6 ignores it
            o_reference_reverse <= signed_fmt && sign_q;
            o_reference_valid <= have_q && !fmt_blocked && !wif.bad;
            o_format_error <= fmt_blocked || (have_q && wif.bad);
        end
    end

    // all-ones binary word means 100 % speed
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_binary_full_scale <= 1'b0;
        end else if (fmt_eff == FMT_BINARY && !force_bcd) begin
            if (wide_eff) begin
                o_binary_full_scale <= &word_q;
            end else if (IS_WIDE) begin
                o_binary_full_scale <= &word_q[11:0];
            end else begin
                o_binary_full_scale <= &word_q[7:0];
            end
        end else begin
            o_binary_full_scale <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // unit class from display scaling
    // ----------------------------------------------------------------
    always_comb begin
        if (i_display_scaling_select == SCALE_HZ) begin
            unit_d = PFRD_UNIT_HZ;
        end else if (i_display_scaling_select == SCALE_PCT) begin
            unit_d = PFRD_UNIT_PCT;
        end else if (i_display_scaling_select <= SCALE_RPM_MAX) begin
            unit_d = PFRD_UNIT_RPM;
        end else begin
            unit_d = PFRD_UNIT_USER;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_reference_unit <= PFRD_UNIT_HZ;
            o_unit_scale <= SCALE_RESET;
        end else begin
            o_reference_unit <= unit_d;
            case (unit_d)
                // pole count or user scale word passed to the consumer, user word capped at SCALE_USER_MAX
                PFRD_UNIT_RPM: o_unit_scale <= i_display_scaling_select;
                PFRD_UNIT_USER: begin
                    if (i_display_scaling_select > SCALE_USER_MAX) begin
                        o_unit_scale <= SCALE_USER_MAX;
                    end else begin
                        o_unit_scale <= i_display_scaling_select;
                    end
                end
                PFRD_UNIT_PCT: o_unit_scale <= FULL_PCT[15:0];
                default: o_unit_scale <= SCALE_HZ;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: bench/pfrd_ctrl_model.sv
// pfrd_ctrl_model: controller presenting a word on the terminal pins
// assumes: bench calls send; pins move only on falling edges
`timescale 1ns/10ps
`default_nettype none
module pfrd_ctrl_model (
    // clock
    input wire logic i_clk,
    // terminal pins
    output logic [9:0] o_first,
    output logic [5:0] o_second,
    output logic o_sign,
    output logic o_strobe
);
    initial begin
        o_first = 10'h000;
        o_second = 6'h00;
        o_sign = 1'b0;
        o_strobe = 1'b0;
    end
    task automatic send(input logic [15:0] w, input logic s);
        @(negedge i_clk);
        {o_second, o_first} = w;
        o_sign = s;
        o_strobe = 1'b1;
        @(negedge i_clk);
        o_strobe = 1'b0;
        // released lines stop carrying the word
        {o_second, o_first} = ~w;
        o_sign = ~s;
    endtask
endmodule
`default_nettype wire

// file: bench/pfrd_chk.sv
// pfrd_chk: port assertions for the reference decoder
// assumes: bound into pfrd_top, single clock domain
`timescale 1ns/10ps
`default_nettype none
module pfrd_chk
    import pfrd_pkg::*;
#(
    parameter int DATA_BITS = WIDE_BITS
)
(
    input wire logic i_clk, i_reset_n, i_sign, i_read_strobe,
    input wire logic [9:0] i_first_terminal_block,
    input wire logic [5:0] i_second_terminal_block,
    input wire logic [2:0] i_digital_input_format_select,
    input wire logic [15:0] i_display_scaling_select,
    input wire logic i_word_width_switch, o_reference_reverse,
    input wire logic [19:0] o_reference_mag,
    input wire logic o_reference_valid, o_binary_full_scale,
    input wire logic o_format_error,
    input wire logic [1:0] o_reference_unit,
    input wire logic [15:0] o_unit_scale
);
    wire logic [2:0] fm = i_digital_input_format_select;
    wire logic [15:0] sc = i_display_scaling_select;
    wire logic [15:0] wd = {i_second_terminal_block,
        i_first_terminal_block};
    wire logic b16 = fm == FMT_BINARY && sc < SCALE_RPM_MIN
        && i_word_width_switch && DATA_BITS == 16;
    wire logic blk = fm == FMT_BCD5 && sc < SCALE_RPM_MIN
        && (!i_word_width_switch || DATA_BITS == 8);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_take;
        i_read_strobe && b16 ##1 b16;
    endsequence
    sequence s_quiet;
        (!i_read_strobe && $stable(fm) && $stable(sc)
            && $stable(i_word_width_switch)) [*3];
    endsequence
    a_reset_clears: assert property (disable iff (1'b0)
        !i_reset_n |=> o_reference_mag == 20'h0 && !o_reference_valid)
        else $error("outputs not cleared by reset");
    a_hold_quiet: assert property (s_quiet |=>
        $stable(o_reference_mag) && $stable(o_reference_reverse))
        else $error("reference moved without strobe");
    a_binary_take: assert property (s_take |=>
        o_reference_mag == {4'h0, $past(wd, 2)})
        else $error("binary word not captured");
    a_full_scale: assert property (s_take |=>
        o_binary_full_scale == ($past(wd, 2) == 16'hFFFF))
        else $error("full scale flag wrong");
    a_sign_take: assert property (s_take |=>
        o_reference_reverse == $past(i_sign, 2))
        else $error("sign not captured");
    a_code6_block: assert property (blk ##1 blk |=>
        o_format_error && !o_reference_valid)
        else $error("blocked five digit code accepted");
    a_unit_pct: assert property ($past(i_reset_n) && sc == SCALE_PCT
        |=> o_reference_unit == 2'h1 && o_unit_scale == 16'h2710)
        else $error("percent unit wrong");
    a_unit_rpm: assert property ($past(i_reset_n) && sc >= SCALE_RPM_MIN
        && sc <= SCALE_RPM_MAX |=> o_reference_unit == 2'h2
        && o_unit_scale == $past(sc))
        else $error("rpm unit wrong");
    a_unit_user: assert property ($past(i_reset_n)
        && sc >= SCALE_USER_MIN && sc <= SCALE_USER_MAX
        |=> o_reference_unit == 2'h3 && o_unit_scale == $past(sc))
        else $error("user unit wrong");
endmodule
bind pfrd_top pfrd_chk #(.DATA_BITS(DATA_BITS)) pfrd_chk_inst (.*);
`default_nettype wire

// file: bench/pfrd_top_bench.sv
// pfrd_top_bench: self-checking bench for the reference decoder
// assumes: controller model drives the terminal pins
`timescale 1ns/10ps
`default_nettype none
module pfrd_top_bench;
    import pfrd_pkg::*;
    logic i_clk, i_reset_n, sw;
    logic [2:0] fmt;
    logic [15:0] scl;
    wire logic [9:0] p1;
    wire logic [5:0] p2;
    wire logic sgn, stb, rev, vld, full, ferr;
    wire logic [19:0] mag;
    wire logic [1:0] unit;
    wire logic [15:0] us;
    int errors, n_compared, cyc;
    pfrd_ctrl_model pfrd_ctrl_model_inst (.i_clk(i_clk), .o_first(p1),
        .o_second(p2), .o_sign(sgn), .o_strobe(stb));
    pfrd_top #(.DATA_BITS(16)) pfrd_top_inst (.i_clk(i_clk),
        .i_reset_n(i_reset_n), .i_first_terminal_block(p1),
        .i_second_terminal_block(p2), .i_sign(sgn), .i_read_strobe(stb),
        .i_digital_input_format_select(fmt), .i_display_scaling_select(scl),
        .i_word_width_switch(sw), .o_reference_mag(mag),
        .o_reference_reverse(rev), .o_reference_valid(vld),
        .o_binary_full_scale(full), .o_format_error(ferr),
        .o_reference_unit(unit), .o_unit_scale(us));
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    task automatic final_report();
        $display("compared %0d mismatched %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            errors = errors + 1;
            final_report();
        end
    end
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [2:0] f, input logic [15:0] s,
        input logic w, input logic [15:0] d, input logic g);
        @(negedge i_clk);
        fmt = f;
        scl = s;
        sw = w;
        pfrd_ctrl_model_inst.send(d, g);
        repeat (3) @(negedge i_clk);
    endtask
    task automatic t_binary();
        run(FMT_BINARY, SCALE_HZ, 1'b1, 16'hFFFF, 1'b1);
        chk(mag, 20'h0FFFF);
        chk({18'h0, full, rev}, 20'h3);
        repeat (4) @(negedge i_clk);
        chk(mag, 20'h0FFFF);
        run(FMT_BINARY, SCALE_HZ, 1'b0, 16'hF123, 1'b0);
        chk(mag, 20'h00123);
        chk({18'h0, full, rev}, 20'h0);
        $display("test binary done");
    endtask
    task automatic t_bcd();
        for (int f = 0; f < 6; f++) begin
            run(3'(f), SCALE_HZ, 1'b1, 16'h1234, 1'b1);
            chk(mag, 20'h004D2);
            chk({18'h0, vld, rev}, 20'h3);
        end
        run(FMT_BCD_1HZ, SCALE_HZ, 1'b0, 16'h9876, 1'b0);
        chk(mag, 20'h0036C);
        run(FMT_BCD5, SCALE_HZ, 1'b1, 16'h91A3, 1'b1);
        chk(mag, 20'h07E5A);
        chk({19'h0, rev}, 20'h0);
        run(FMT_BCD5, SCALE_HZ, 1'b0, 16'h91A3, 1'b0);
        chk({18'h0, ferr, vld}, 20'h2);
        $display("test bcd done");
    endtask
    task automatic t_scale();
        logic [15:0] sv [5] = '{16'h0, 16'h1, 16'h27, 16'h28, 16'h9C3F};
        logic [1:0] eu [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
        logic [15:0] es [5] = '{16'h0, 16'h2710, 16'h27, 16'h28, 16'h9C3F};
        for (int i = 0; i < 5; i++) begin
            @(negedge i_clk);
            scl = sv[i];
            repeat (2) @(negedge i_clk);
            chk({2'h0, unit, us}, {2'h0, eu[i], es[i]});
        end
        run(FMT_BINARY, 16'h0004, 1'b1, 16'h0042, 1'b0);
        chk(mag, 20'h0002A);
        chk({2'h0, unit, us}, 20'h20004);
        $display("test scale done");
    endtask
    initial begin
        i_reset_n = 1'b0;
        fmt = FMT_RESET;
        scl = SCALE_RESET;
        sw = 1'b1;
        repeat (12) @(negedge i_clk);
        chk({mag[18:0], vld}, 20'h0);
        i_reset_n = 1'b1;
        t_binary();
        t_bcd();
        t_scale();
        final_report();
    end
endmodule
`default_nettype wire
